// ### src/fsp_flash_dev.sv
// Flash device end: per-partition status, page buffer status, partition layout
// How it works
// - Bit 7 shows partition ready, zero when busy
// - Bit 6 set while erase is suspended
// - Bit 5 set on failed erase
// - Bit 4 set on failed program or OTP
// - Accelerator pin fault aborts, sets bit 3
// - Bit 2 set while program is suspended
// - Locked target aborts operation, sets bit 1
// - Status follows addressed partition, not engine
// - Host ignores bits 6..1 while busy
// - Improper sequence sets bits 5 and 4
// - Bit 3 updated only at operation start
// - Bit 1 updated only at operation start
// - Host polls bit 7 or ready output
// - Host masks reserved status bits
// - Page buffer command sets availability bit
// - Host reissues page command when unavailable
// - Layout 000 single partition, no dual work
// - Codes 001, 010, 100 give two partitions
// - Codes 011, 101, 110 give three partitions
// - Code 111 gives four partitions
// - Reset layout 001 bottom, 100 top
// - Host masks reserved configuration bits
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_dev #(
	parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYCLES_DEF,
	parameter int PROGRAM_CYCLES = fsp_pkg::PROGRAM_CYCLES_DEF,
	parameter bit TOP_PARAM = 1'b0
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	fsp_link_if.dev LINK,
	input wire logic ACCEL_PIN_FAULT,
	input wire logic BLOCK_LOCKED,
	input wire logic ERASE_FAIL,
	input wire logic PROGRAM_FAIL,
	input wire logic PAGE_BUFFER_FREE,
	output logic [2:0] LAYOUT_CODE,
	output logic DUAL_WORK_ALLOWED
);
	localparam logic [15:0] ERASE_LEN = 16'(ERASE_CYCLES - 1);
	localparam logic [15:0] PROGRAM_LEN = 16'(PROGRAM_CYCLES - 1);
	localparam logic [2:0] LAYOUT_RESET =
		TOP_PARAM ? fsp_pkg::PCR_TOP_RESET : fsp_pkg::PCR_BOTTOM_RESET;

	logic acc_s1_reg, acc_s2_reg, acc_s3_reg, acc_lvl_reg;
	logic [2:0] layout_reg;
	logic xsr_avail_reg;
	logic eng_active_reg, eng_susp_reg, eng_erase_reg;
	logic [1:0] eng_part_reg;
	logic [15:0] eng_cnt_reg;
	logic [3:0] busy_reg, esus_reg, psus_reg, eerr_reg, perr_reg, accf_reg, lock_reg;
	logic [3:0] busy_next, esus_next, psus_next, eerr_next, perr_next, accf_next, lock_next;
	logic resp_valid_reg, ready_reg;
	logic [15:0] resp_data_reg, resp_data_next;
	logic [1:0] req_part;

	// Plane to partition decode
	fsp_plane_map u_fsp_plane_map (
		.code(layout_reg),
		.plane(LINK.req_plane),
		.part(req_part)
	);

	wire take = LINK.req_valid;
	wire [7:0] cmd = LINK.req_cmd;
	wire [7:0] conf = LINK.req_data[7:0];
	wire is_erase = take & ((cmd == fsp_pkg::CMD_ERASE) | (cmd == fsp_pkg::CMD_CHIP_ERASE));
	wire is_prog = take & ((cmd == fsp_pkg::CMD_PROGRAM) | (cmd == fsp_pkg::CMD_OTP));
	wire is_page = take & (cmd == fsp_pkg::CMD_PAGE);
	wire is_lock = take & (cmd == fsp_pkg::CMD_LOCK);
	wire is_cfg = take & (cmd == fsp_pkg::CMD_CONFIG);
	wire is_clear = take & (cmd == fsp_pkg::CMD_CLEAR);
	wire erase_conf = conf == fsp_pkg::CONF_ERASE;
	wire lock_conf = (conf == fsp_pkg::CONF_LOCK_SET) | (conf == fsp_pkg::CONF_LOCK_CLEAR)
		| (conf == fsp_pkg::CONF_LOCK_DOWN);
	wire cfg_conf = conf == fsp_pkg::CONF_CONFIG;
	wire page_ok = is_page & PAGE_BUFFER_FREE & ~eng_active_reg;
	wire start_ok = ~eng_active_reg & ((is_erase & erase_conf) | is_prog | page_ok);
	wire abort_accel = start_ok & acc_lvl_reg;
	wire abort_lock = start_ok & BLOCK_LOCKED;
	wire launch = start_ok & ~acc_lvl_reg & ~BLOCK_LOCKED;
	wire improper = (is_erase & ~erase_conf) | (is_lock & ~lock_conf) | (is_cfg & ~cfg_conf)
		| ((is_erase | is_prog) & eng_active_reg);
	wire same_part = req_part == eng_part_reg;
	wire done = eng_active_reg & ~eng_susp_reg & (eng_cnt_reg == 16'h0000);
	// No suspend in the finishing cycle, else the suspend bit sticks
	wire suspend = take & (cmd == fsp_pkg::CMD_SUSPEND) & eng_active_reg & ~eng_susp_reg
		& same_part & ~done;
	wire resume = take & (cmd == fsp_pkg::CMD_RESUME) & eng_susp_reg & same_part;
	wire launch_erase = is_erase;

	// Per-partition status updates; sets come last so they win over a clear
	always_comb begin
		busy_next = busy_reg;
		esus_next = esus_reg;
		psus_next = psus_reg;
		eerr_next = eerr_reg;
		perr_next = perr_reg;
		accf_next = accf_reg;
		lock_next = lock_reg;
		for (int i = 0; i < 4; i++) begin
			if ((is_clear | launch) && req_part == 2'(i)) begin
				eerr_next[i] = 1'b0;
				perr_next[i] = 1'b0;
				accf_next[i] = 1'b0;
				lock_next[i] = 1'b0;
			end
			if (launch && req_part == 2'(i)) begin
				busy_next[i] = 1'b1;
			end
			if (suspend && eng_part_reg == 2'(i)) begin
				busy_next[i] = 1'b0;
				esus_next[i] = eng_erase_reg;
				psus_next[i] = ~eng_erase_reg;
			end
			if (resume && eng_part_reg == 2'(i)) begin
				busy_next[i] = 1'b1;
				esus_next[i] = 1'b0;
				psus_next[i] = 1'b0;
			end
			if (done && eng_part_reg == 2'(i)) begin
				busy_next[i] = 1'b0;
				eerr_next[i] = eerr_reg[i] | (eng_erase_reg & ERASE_FAIL);
				perr_next[i] = perr_reg[i] | (~eng_erase_reg & PROGRAM_FAIL);
			end
			if (abort_accel && req_part == 2'(i)) begin
				accf_next[i] = 1'b1;
			end
			if (abort_lock && req_part == 2'(i)) begin
				lock_next[i] = 1'b1;
			end
			if (improper && req_part == 2'(i)) begin
				eerr_next[i] = 1'b1;
				perr_next[i] = 1'b1;
			end
		end
	end

	// Read answers for the addressed partition
	always_comb begin
		resp_data_next = 16'h0000;
		if (cmd == fsp_pkg::CMD_READ_SR) begin
			resp_data_next[fsp_pkg::SR_READY] = ~busy_reg[req_part];
			resp_data_next[fsp_pkg::SR_ESUS] = esus_reg[req_part];
			resp_data_next[fsp_pkg::SR_EERR] = eerr_reg[req_part];
			resp_data_next[fsp_pkg::SR_PERR] = perr_reg[req_part];
			resp_data_next[fsp_pkg::SR_ACCF] = accf_reg[req_part];
			resp_data_next[fsp_pkg::SR_PSUS] = psus_reg[req_part];
			resp_data_next[fsp_pkg::SR_LOCK] = lock_reg[req_part];
		end else if (cmd == fsp_pkg::CMD_READ_XSR) begin
			resp_data_next[fsp_pkg::XSR_AVAIL] = xsr_avail_reg;
		end else if (cmd == fsp_pkg::CMD_READ_PCR) begin
			resp_data_next[fsp_pkg::PCR_MSB:fsp_pkg::PCR_LSB] = layout_reg;
		end
	end

	wire is_read = take & ((cmd == fsp_pkg::CMD_READ_SR) | (cmd == fsp_pkg::CMD_READ_XSR)
		| (cmd == fsp_pkg::CMD_READ_PCR));

	// Accelerator pin synchroniser with agreement filter
	always_ff @(posedge SYS_CLK) begin
		acc_s1_reg <= ACCEL_PIN_FAULT;
		acc_s2_reg <= acc_s1_reg;
		acc_s3_reg <= acc_s2_reg;
		if (SYS_RST) begin
			acc_lvl_reg <= 1'b0;
		end else if (acc_s2_reg == acc_s3_reg) begin
			acc_lvl_reg <= acc_s3_reg;
		end
	end

	// Layout and page buffer status
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			layout_reg <= LAYOUT_RESET;
			xsr_avail_reg <= 1'b0;
		end else begin
			if (is_cfg && cfg_conf) begin
				layout_reg <= LINK.req_data[fsp_pkg::PCR_MSB:fsp_pkg::PCR_LSB];
			end
			if (is_page) begin
				xsr_avail_reg <= page_ok;
			end
		end
	end

	// Shared write engine
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			eng_active_reg <= 1'b0;
			eng_susp_reg <= 1'b0;
			eng_erase_reg <= 1'b0;
			eng_part_reg <= 2'b00;
			eng_cnt_reg <= 16'h0000;
		end else if (launch) begin
			eng_active_reg <= 1'b1;
			eng_erase_reg <= launch_erase;
			eng_part_reg <= req_part;
			eng_cnt_reg <= launch_erase ? ERASE_LEN : PROGRAM_LEN;
		end else if (done) begin
			eng_active_reg <= 1'b0;
		end else if (suspend) begin
			eng_susp_reg <= 1'b1;
		end else if (resume) begin
			eng_susp_reg <= 1'b0;
		end else if (eng_active_reg && !eng_susp_reg) begin
			eng_cnt_reg <= eng_cnt_reg - 16'h0001;
		end
	end

	// Partition status vectors
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			busy_reg <= 4'h0;
			esus_reg <= 4'h0;
			psus_reg <= 4'h0;
			eerr_reg <= 4'h0;
			perr_reg <= 4'h0;
			accf_reg <= 4'h0;
			lock_reg <= 4'h0;
		end else begin
			busy_reg <= busy_next;
			esus_reg <= esus_next;
			psus_reg <= psus_next;
			eerr_reg <= eerr_next;
			perr_reg <= perr_next;
			accf_reg <= accf_next;
			lock_reg <= lock_next;
		end
	end

	// Link answers
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			resp_valid_reg <= 1'b0;
			resp_data_reg <= 16'h0000;
			ready_reg <= 1'b1;
		end else begin
			resp_valid_reg <= is_read;
			if (is_read) begin
				resp_data_reg <= resp_data_next;
			end
			ready_reg <= ~((eng_active_reg & ~eng_susp_reg & ~done) | launch | resume);
		end
	end

	assign LINK.resp_valid = resp_valid_reg;
	assign LINK.resp_data = resp_data_reg;
	assign LINK.ready_busy_output = ready_reg;
	assign LAYOUT_CODE = layout_reg;
	assign DUAL_WORK_ALLOWED = layout_reg != fsp_pkg::LAYOUT_NONE;
endmodule : fsp_flash_dev
`default_nettype wire

// ### src/fsp_flash_host.sv
// Host end: issues commands, polls status, masks reserved bits
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_host #(
	parameter int PAGE_RETRY = fsp_pkg::PAGE_RETRY_DEF
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	fsp_link_if.host LINK,
	input wire logic USER_REQ,
	input wire logic [7:0] USER_CMD,
	input wire logic [1:0] USER_PLANE,
	input wire logic [15:0] USER_DATA,
	output logic USER_BUSY,
	output logic USER_DONE,
	output logic USER_PAGE_REFUSED,
	output logic [15:0] USER_RESULT
);
	localparam logic [7:0] RETRY_MAX = 8'(PAGE_RETRY);

	fsp_pkg::fsp_host_state_e state_reg;
	logic [7:0] cmd_reg;
	logic [1:0] plane_reg;
	logic [15:0] data_reg;
	logic [7:0] retry_reg;
	logic req_valid_reg;
	logic [7:0] req_cmd_reg;
	logic [15:0] req_data_reg;
	logic done_reg, refused_reg;
	logic [15:0] result_reg;

	// Status bits 6..1 only mean something once ready is seen
	function automatic logic [15:0] mask_status(input logic [15:0] raw);
		logic [15:0] m;
		m = raw & fsp_pkg::SR_MASK;
		if (!raw[fsp_pkg::SR_READY]) begin
			m = 16'h0000;
		end
		return m;
	endfunction : mask_status

	wire is_read = (USER_CMD == fsp_pkg::CMD_READ_SR) | (USER_CMD == fsp_pkg::CMD_READ_XSR)
		| (USER_CMD == fsp_pkg::CMD_READ_PCR);
	wire is_op = (USER_CMD == fsp_pkg::CMD_ERASE) | (USER_CMD == fsp_pkg::CMD_CHIP_ERASE)
		| (USER_CMD == fsp_pkg::CMD_PROGRAM) | (USER_CMD == fsp_pkg::CMD_OTP);
	wire is_page = USER_CMD == fsp_pkg::CMD_PAGE;
	wire [15:0] rd_masked = (cmd_reg == fsp_pkg::CMD_READ_SR) ? mask_status(LINK.resp_data)
		: (cmd_reg == fsp_pkg::CMD_READ_XSR) ? (LINK.resp_data & fsp_pkg::XSR_MASK)
		: (LINK.resp_data & fsp_pkg::PCR_MASK);
	wire xsr_free = LINK.resp_data[fsp_pkg::XSR_AVAIL];
	wire sr_ready = LINK.resp_data[fsp_pkg::SR_READY];

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_reg <= fsp_pkg::HS_IDLE;
			cmd_reg <= 8'h00;
			plane_reg <= 2'b00;
			data_reg <= 16'h0000;
			retry_reg <= 8'h00;
			req_valid_reg <= 1'b0;
			req_cmd_reg <= 8'h00;
			req_data_reg <= 16'h0000;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			result_reg <= 16'h0000;
		end else begin
			req_valid_reg <= 1'b0;
			done_reg <= 1'b0;
			case (state_reg)
				fsp_pkg::HS_IDLE: begin
					if (USER_REQ) begin
						cmd_reg <= USER_CMD;
						plane_reg <= USER_PLANE;
						data_reg <= USER_DATA;
						retry_reg <= 8'h00;
						refused_reg <= 1'b0;
						req_valid_reg <= 1'b1;
						req_cmd_reg <= USER_CMD;
						req_data_reg <= USER_DATA;
						if (is_read) begin
							state_reg <= fsp_pkg::HS_WAIT_RD;
						end else if (is_page) begin
							state_reg <= fsp_pkg::HS_XSR_SEND;
						end else if (is_op) begin
							state_reg <= fsp_pkg::HS_POLL_SEND;
						end else begin
							done_reg <= 1'b1;
							result_reg <= 16'h0000;
						end
					end
				end
				fsp_pkg::HS_WAIT_RD: begin
					if (LINK.resp_valid) begin
						result_reg <= rd_masked;
						done_reg <= 1'b1;
						state_reg <= fsp_pkg::HS_IDLE;
					end
				end
				fsp_pkg::HS_XSR_SEND: begin
					req_valid_reg <= 1'b1;
					req_cmd_reg <= fsp_pkg::CMD_READ_XSR;
					state_reg <= fsp_pkg::HS_XSR_WAIT;
				end
				fsp_pkg::HS_XSR_WAIT: begin
					if (LINK.resp_valid) begin
						if (xsr_free) begin
							state_reg <= fsp_pkg::HS_POLL_SEND;
						end else if (retry_reg < RETRY_MAX) begin
							retry_reg <= retry_reg + 8'h01;
							req_valid_reg <= 1'b1;
							req_cmd_reg <= fsp_pkg::CMD_PAGE;
							req_data_reg <= data_reg;
							state_reg <= fsp_pkg::HS_XSR_SEND;
						end else begin
							refused_reg <= 1'b1;
							result_reg <= LINK.resp_data & fsp_pkg::XSR_MASK;
							done_reg <= 1'b1;
							state_reg <= fsp_pkg::HS_IDLE;
						end
					end
				end
				fsp_pkg::HS_POLL_SEND: begin
					req_valid_reg <= 1'b1;
					req_cmd_reg <= fsp_pkg::CMD_READ_SR;
					state_reg <= fsp_pkg::HS_POLL_WAIT;
				end
				fsp_pkg::HS_POLL_WAIT: begin
					if (LINK.resp_valid) begin
						if (sr_ready) begin
							result_reg <= mask_status(LINK.resp_data);
							done_reg <= 1'b1;
							state_reg <= fsp_pkg::HS_IDLE;
						end else begin
							state_reg <= fsp_pkg::HS_POLL_SEND;
						end
					end
				end
				default: state_reg <= fsp_pkg::HS_IDLE;
			endcase
		end
	end

	assign LINK.req_valid = req_valid_reg;
	assign LINK.req_cmd = req_cmd_reg;
	assign LINK.req_plane = plane_reg;
	assign LINK.req_data = req_data_reg;
	assign USER_BUSY = state_reg != fsp_pkg::HS_IDLE;
	assign USER_DONE = done_reg;
	assign USER_PAGE_REFUSED = refused_reg;
	assign USER_RESULT = result_reg;
endmodule : fsp_flash_host
`default_nettype wire

// ### src/fsp_link_if.sv
// Link between the flash host controller and the flash status logic
`timescale 1ns/1ps
`default_nettype none
interface fsp_link_if;
	logic req_valid;
	logic [7:0] req_cmd;
	logic [1:0] req_plane;
	logic [15:0] req_data;
	logic resp_valid;
	logic [15:0] resp_data;
	logic ready_busy_output;

	modport dev (
		input req_valid,
		input req_cmd,
		input req_plane,
		input req_data,
		output resp_valid,
		output resp_data,
		output ready_busy_output
	);

	modport host (
		output req_valid,
		output req_cmd,
		output req_plane,
		output req_data,
		input resp_valid,
		input resp_data,
		input ready_busy_output
	);
endinterface : fsp_link_if
`default_nettype wire

// ### src/fsp_pkg.sv
// Shared constants and types for the flash status and partition logic
package fsp_pkg;
	// Command codes carried on the link
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_OTP = 8'hc0;
	localparam logic [7:0] CMD_PAGE = 8'he8;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'hd0;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam logic [7:0] CMD_READ_SR = 8'h70;
	localparam logic [7:0] CMD_READ_XSR = 8'h71;
	localparam logic [7:0] CMD_READ_PCR = 8'h90;
	localparam logic [7:0] CMD_LOCK = 8'h60;
	localparam logic [7:0] CMD_CONFIG = 8'h61;
	// Confirm codes in the low data byte
	localparam logic [7:0] CONF_ERASE = 8'hd0;
	localparam logic [7:0] CONF_LOCK_SET = 8'h01;
	localparam logic [7:0] CONF_LOCK_CLEAR = 8'hd0;
	localparam logic [7:0] CONF_LOCK_DOWN = 8'h2f;
	localparam logic [7:0] CONF_CONFIG = 8'h04;
	// Status bit positions
	localparam int SR_READY = 7;
	localparam int SR_ESUS = 6;
	localparam int SR_EERR = 5;
	localparam int SR_PERR = 4;
	localparam int SR_ACCF = 3;
	localparam int SR_PSUS = 2;
	localparam int SR_LOCK = 1;
	localparam int XSR_AVAIL = 7;
	localparam int PCR_LSB = 8;
	localparam int PCR_MSB = 10;
	// Reserved-bit masks
	localparam logic [15:0] SR_MASK = 16'h00fe;
	localparam logic [15:0] XSR_MASK = 16'h0080;
	localparam logic [15:0] PCR_MASK = 16'h0700;
	// Reset layouts
	localparam logic [2:0] PCR_BOTTOM_RESET = 3'b001;
	localparam logic [2:0] PCR_TOP_RESET = 3'b100;
	// Default operation lengths in cycles and page retry count
	localparam int ERASE_CYCLES_DEF = 64;
	localparam int PROGRAM_CYCLES_DEF = 16;
	localparam int PAGE_RETRY_DEF = 4;

	typedef enum logic [2:0] {
		LAYOUT_NONE = 3'b000,
		LAYOUT_P0_P123 = 3'b001,
		LAYOUT_P01_P23 = 3'b010,
		LAYOUT_P0_P1_P23 = 3'b011,
		LAYOUT_P012_P3 = 3'b100,
		LAYOUT_P0_P12_P3 = 3'b101,
		LAYOUT_P01_P2_P3 = 3'b110,
		LAYOUT_FOUR = 3'b111
	} fsp_layout_e;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_WAIT_RD = 3'b001,
		HS_XSR_SEND = 3'b010,
		HS_XSR_WAIT = 3'b011,
		HS_POLL_SEND = 3'b100,
		HS_POLL_WAIT = 3'b101
	} fsp_host_state_e;
endpackage : fsp_pkg

// ### src/fsp_plane_map.sv
// Plane to partition index decoder for the layout code
`timescale 1ns/1ps
`default_nettype none
module fsp_plane_map (
	input wire logic [2:0] code,
	input wire logic [1:0] plane,
	output logic [1:0] part
);
	logic [7:0] map;

	// Partition index of planes 3..2..1..0, two bits each
	always_comb begin
		case (fsp_pkg::fsp_layout_e'(code))
			fsp_pkg::LAYOUT_NONE: map = 8'h00;
			fsp_pkg::LAYOUT_P0_P123: map = 8'h54;
			fsp_pkg::LAYOUT_P01_P23: map = 8'h50;
			fsp_pkg::LAYOUT_P012_P3: map = 8'h40;
			fsp_pkg::LAYOUT_P0_P1_P23: map = 8'ha4;
			fsp_pkg::LAYOUT_P0_P12_P3: map = 8'h94;
			fsp_pkg::LAYOUT_P01_P2_P3: map = 8'h90;
			fsp_pkg::LAYOUT_FOUR: map = 8'he4;
			default: map = 8'h00;
		endcase
	end

	assign part = map[{plane, 1'b0} +: 2];
endmodule : fsp_plane_map
`default_nettype wire

// ### verification/fsp_link_props.sv
// Link checker for the flash status logic
`timescale 1ns/1ps
`default_nettype none
module fsp_link_props (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic req_valid,
	input wire logic [7:0] req_cmd,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	input wire logic ready_busy_output
);
	localparam int BUSY_MAX = 16;
	wire is_read;
	assign is_read = req_valid && (req_cmd == fsp_pkg::CMD_READ_SR
		|| req_cmd == fsp_pkg::CMD_READ_XSR || req_cmd == fsp_pkg::CMD_READ_PCR);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	a_read_gets_answer: assert property (is_read |=> resp_valid)
		else $error("read not answered next cycle");
	a_answer_has_cause: assert property (resp_valid |-> $past(is_read))
		else $error("answer without read");
	a_answer_holds: assert property (!resp_valid |-> $stable(resp_data))
		else $error("read data moved without read");
	a_status_reserved_zero: assert property (resp_valid && $past(req_cmd) == fsp_pkg::CMD_READ_SR
		|-> (resp_data & ~fsp_pkg::SR_MASK) == 16'h0000)
		else $error("status reserved bits set");
	a_xsr_only_avail: assert property (resp_valid && $past(req_cmd) == fsp_pkg::CMD_READ_XSR
		|-> (resp_data & ~fsp_pkg::XSR_MASK) == 16'h0000)
		else $error("extended status reserved bits set");
	a_pcr_only_layout: assert property (resp_valid && $past(req_cmd) == fsp_pkg::CMD_READ_PCR
		|-> (resp_data & ~fsp_pkg::PCR_MASK) == 16'h0000)
		else $error("configuration reserved bits set");
	a_busy_bounded: assert property ($fell(ready_busy_output)
		|-> ##[1:BUSY_MAX] ready_busy_output)
		else $error("busy too long");
	a_ready_after_reset: assert property ($fell(SYS_RST)
		|-> ready_busy_output && !resp_valid)
		else $error("not ready after reset");

	cover property ($fell(ready_busy_output));
	cover property (resp_valid && $past(req_cmd) == fsp_pkg::CMD_READ_PCR);
	cover property (req_valid && req_cmd == fsp_pkg::CMD_PAGE);
endmodule : fsp_link_props
`default_nettype wire

// ### verification/fsp_tb.sv
// Testbench joining host and device ends, plus a directly driven device
`timescale 1ns/1ps
`default_nettype none
module fsp_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic accel = 1'b0, locked = 1'b0, efail = 1'b0, pfail = 1'b0, pfree = 1'b1;
	logic usr_req = 1'b0;
	logic [7:0] usr_cmd = 8'h00;
	logic [1:0] usr_plane = 2'h0;
	logic [15:0] usr_data = 16'h0000;
	logic usr_busy, usr_done, usr_refused, dual_a, dual_b;
	logic [15:0] usr_result;
	logic [2:0] layout_a;
	logic [15:0] d;
	int err_count = 0;
	int comparisons = 0;
	always #10 sys_clk = ~sys_clk;

	fsp_link_if link ();
	fsp_link_if link_b ();
	fsp_flash_dev #(.ERASE_CYCLES(4), .PROGRAM_CYCLES(2)) u_fsp_flash_dev (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(link.dev), .ACCEL_PIN_FAULT(accel),
		.BLOCK_LOCKED(locked), .ERASE_FAIL(efail), .PROGRAM_FAIL(pfail),
		.PAGE_BUFFER_FREE(pfree), .LAYOUT_CODE(layout_a), .DUAL_WORK_ALLOWED(dual_a));
	fsp_flash_host u_fsp_flash_host (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(link.host), .USER_REQ(usr_req),
		.USER_CMD(usr_cmd), .USER_PLANE(usr_plane), .USER_DATA(usr_data),
		.USER_BUSY(usr_busy), .USER_DONE(usr_done), .USER_PAGE_REFUSED(usr_refused),
		.USER_RESULT(usr_result));
	fsp_flash_dev #(.ERASE_CYCLES(40), .PROGRAM_CYCLES(16), .TOP_PARAM(1'b1)) u_fsp_flash_dev_b (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(link_b.dev), .ACCEL_PIN_FAULT(accel),
		.BLOCK_LOCKED(locked), .ERASE_FAIL(efail), .PROGRAM_FAIL(pfail),
		.PAGE_BUFFER_FREE(pfree), .LAYOUT_CODE(), .DUAL_WORK_ALLOWED(dual_b));
	fsp_link_props u_fsp_link_props (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .req_valid(link.req_valid),
		.req_cmd(link.req_cmd), .resp_valid(link.resp_valid), .resp_data(link.resp_data),
		.ready_busy_output(link.ready_busy_output));

	task finish_test;
		$display("Counts: err_count %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task stall;
		err_count++;
		$display("MISMATCH t=%0t wait ran out", $time);
		finish_test();
	endtask : stall

	task user_op(input logic [7:0] cmd, input logic [1:0] plane, input logic [15:0] data);
		int i;
		@(negedge sys_clk);
		usr_req = 1'b1;
		usr_cmd = cmd;
		usr_plane = plane;
		usr_data = data;
		@(negedge sys_clk);
		usr_req = 1'b0;
		for (i = 0; i < 2000 && usr_done !== 1'b1; i++) @(negedge sys_clk);
		if (i == 2000) stall();
		chk({15'h0000, usr_busy}, 16'h0000);
	endtask : user_op

	task dsend(input logic [7:0] cmd, input logic [1:0] plane, input logic [15:0] data);
		@(negedge sys_clk);
		link_b.req_valid = 1'b1;
		link_b.req_cmd = cmd;
		link_b.req_plane = plane;
		link_b.req_data = data;
		@(negedge sys_clk);
		link_b.req_valid = 1'b0;
		link_b.req_cmd = ~cmd;
		link_b.req_data = ~data;
	endtask : dsend

	task dread(input logic [7:0] cmd, input logic [1:0] plane);
		dsend(cmd, plane, 16'h0000);
		if (link_b.resp_valid !== 1'b1) stall();
		d = link_b.resp_data;
	endtask : dread

	task wait_rdy;
		int i;
		for (i = 0; i < 500 && link_b.ready_busy_output !== 1'b1; i++) @(negedge sys_clk);
		if (i == 500) stall();
	endtask : wait_rdy

	task s_reset;
		user_op(fsp_pkg::CMD_READ_PCR, 2'h0, 16'h0000);
		chk(usr_result, 16'h0100);
		chk({13'h0000, layout_a}, 16'h0001);
		chk({15'h0000, dual_a}, 16'h0001);
		user_op(fsp_pkg::CMD_READ_SR, 2'h2, 16'h0000);
		chk(usr_result, 16'h0080);
		user_op(fsp_pkg::CMD_READ_XSR, 2'h0, 16'h0000);
		chk(usr_result, 16'h0000);
	endtask : s_reset

	task s_errors;
		efail = 1'b1;
		user_op(fsp_pkg::CMD_ERASE, 2'h1, 16'h00d0);
		chk(usr_result, 16'h00a0);
		efail = 1'b0;
		user_op(fsp_pkg::CMD_ERASE, 2'h1, 16'h00d0);
		chk(usr_result, 16'h0080);
		pfail = 1'b1;
		user_op(fsp_pkg::CMD_PROGRAM, 2'h3, 16'h5a5a);
		chk(usr_result, 16'h0090);
		pfail = 1'b0;
		user_op(fsp_pkg::CMD_PROGRAM, 2'h3, 16'ha5a5);
		chk(usr_result, 16'h0080);
		pfail = 1'b1;
		user_op(fsp_pkg::CMD_OTP, 2'h3, 16'h1234);
		chk(usr_result, 16'h0090);
		pfail = 1'b0;
		user_op(fsp_pkg::CMD_CLEAR, 2'h3, 16'h0000);
		user_op(fsp_pkg::CMD_READ_SR, 2'h3, 16'h0000);
		chk(usr_result, 16'h0080);
	endtask : s_errors

	task s_protect;
		locked = 1'b1;
		user_op(fsp_pkg::CMD_ERASE, 2'h0, 16'h00d0);
		chk(usr_result, 16'h0082);
		locked = 1'b0;
		user_op(fsp_pkg::CMD_READ_SR, 2'h0, 16'h0000);
		chk(usr_result, 16'h0082);
		user_op(fsp_pkg::CMD_CLEAR, 2'h0, 16'h0000);
		accel = 1'b1;
		repeat (5) @(negedge sys_clk);
		user_op(fsp_pkg::CMD_PROGRAM, 2'h0, 16'h1111);
		chk(usr_result, 16'h0088);
		accel = 1'b0;
		repeat (5) @(negedge sys_clk);
		user_op(fsp_pkg::CMD_READ_SR, 2'h0, 16'h0000);
		chk(usr_result, 16'h0088);
		user_op(fsp_pkg::CMD_ERASE, 2'h0, 16'h00d0);
		chk(usr_result, 16'h0080);
	endtask : s_protect

	task s_page;
		pfree = 1'b0;
		user_op(fsp_pkg::CMD_PAGE, 2'h1, 16'h0000);
		chk({15'h0000, usr_refused}, 16'h0001);
		pfree = 1'b1;
		user_op(fsp_pkg::CMD_PAGE, 2'h1, 16'h0000);
		chk({15'h0000, usr_refused}, 16'h0000);
		chk(usr_result, 16'h0080);
	endtask : s_page

	task s_layouts;
		logic [3:0] same2 [0:7];
		logic [2:0] lc;
		same2 = '{4'b1111, 4'b1110, 4'b1100, 4'b1100, 4'b0111, 4'b0110, 4'b0100, 4'b0100};
		dread(fsp_pkg::CMD_READ_PCR, 2'h0);
		chk(d, 16'h0400);
		chk({15'h0000, dual_b}, 16'h0001);
		for (int c = 0; c < 8; c++) begin
			lc = c[2:0];
			dsend(fsp_pkg::CMD_CONFIG, 2'h0, {5'h00, lc, fsp_pkg::CONF_CONFIG});
			dread(fsp_pkg::CMD_READ_PCR, 2'h0);
			chk(d, {5'h00, lc, 8'h00});
			chk({15'h0000, dual_b}, {15'h0000, lc != 3'b000});
			dsend(fsp_pkg::CMD_ERASE, 2'h2, 16'h00d0);
			for (int p = 0; p < 4; p++) begin
				dread(fsp_pkg::CMD_READ_SR, p[1:0]);
				chk({15'h0000, d[7]}, {15'h0000, ~same2[c][p]});
			end
			wait_rdy();
		end
	endtask : s_layouts

	task s_improper_suspend;
		dsend(fsp_pkg::CMD_ERASE, 2'h1, 16'h0011);
		dread(fsp_pkg::CMD_READ_SR, 2'h1);
		chk(d, 16'h00b0);
		dsend(fsp_pkg::CMD_ERASE, 2'h1, 16'h00d0);
		dsend(fsp_pkg::CMD_SUSPEND, 2'h1, 16'h0000);
		dread(fsp_pkg::CMD_READ_SR, 2'h1);
		chk(d, 16'h00c0);
		dsend(fsp_pkg::CMD_RESUME, 2'h1, 16'h0000);
		dread(fsp_pkg::CMD_READ_SR, 2'h1);
		chk(d & 16'h00c0, 16'h0000);
		wait_rdy();
		dsend(fsp_pkg::CMD_PROGRAM, 2'h1, 16'h2222);
		dsend(fsp_pkg::CMD_SUSPEND, 2'h1, 16'h0000);
		dread(fsp_pkg::CMD_READ_SR, 2'h1);
		chk(d, 16'h0084);
		dsend(fsp_pkg::CMD_RESUME, 2'h1, 16'h0000);
		wait_rdy();
		dread(fsp_pkg::CMD_READ_SR, 2'h1);
		chk(d, 16'h0080);
	endtask : s_improper_suspend

	initial begin
		link_b.req_valid = 1'b0;
		link_b.req_cmd = 8'h00;
		link_b.req_plane = 2'h0;
		link_b.req_data = 16'h0000;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		s_reset();
		s_errors();
		s_protect();
		s_page();
		s_layouts();
		s_improper_suspend();
		finish_test();
	end
endmodule : fsp_tb
`default_nettype wire
